// ---- rtl/dsd_pkg.sv ----
package dsd_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] DSD_OFF_METHOD   = 8'h00;
    localparam logic [7:0] DSD_OFF_UNIT     = 8'h04;
    localparam logic [7:0] DSD_OFF_BCD_BIAS = 8'h08;
    localparam logic [7:0] DSD_OFF_BCD_GAIN = 8'h0C;
    localparam logic [7:0] DSD_OFF_BIN_BIAS = 8'h10;
    localparam logic [7:0] DSD_OFF_BIN_GAIN = 8'h14;
    localparam logic [7:0] DSD_OFF_TQ_BIAS  = 8'h18;
    localparam logic [7:0] DSD_OFF_TQ_GAIN  = 8'h1C;
    localparam logic [7:0] DSD_OFF_TQ_SRC   = 8'h20;
    localparam logic [7:0] DSD_OFF_ACC_REF  = 8'h24;
    localparam logic [7:0] DSD_OFF_STATUS   = 8'h28;
    localparam logic [7:0] DSD_OFF_FREQ     = 8'h2C;
    localparam logic [7:0] DSD_OFF_TORQUE   = 8'h30;

    // Values after reset (gains and biases in 0.1 units)
    localparam logic [13:0] DSD_RST_METHOD  = 14'h270F;
    localparam logic [1:0]  DSD_RST_UNIT    = 2'h1;
    localparam logic [15:0] DSD_RST_F_BIAS  = 16'h0000;
    localparam logic [15:0] DSD_RST_F_GAIN  = 16'h0258;
    localparam logic [15:0] DSD_RST_TQ_BIAS = 16'h0000;
    localparam logic [15:0] DSD_RST_TQ_GAIN = 16'h05DC;
    localparam logic [2:0]  DSD_RST_TQ_SRC  = 3'h0;
    localparam logic [31:0] DSD_RST_ACC_REF = 32'h0000_1770;

    // Direct-value code in any gain register
    localparam logic [15:0] DSD_GAIN_DIRECT = 16'h270F;

    // Input method codes
    localparam logic [13:0] DSD_M_BCD3      = 14'h0000;
    localparam logic [13:0] DSD_M_BIN12     = 14'h0001;
    localparam logic [13:0] DSD_M_BCD3_CMP  = 14'h0002;
    localparam logic [13:0] DSD_M_BIN12_CMP = 14'h0003;
    localparam logic [13:0] DSD_M_TQ12      = 14'h0004;
    localparam logic [13:0] DSD_M_BCD4      = 14'h000A;
    localparam logic [13:0] DSD_M_BIN16     = 14'h000B;
    localparam logic [13:0] DSD_M_BCD4_CMP  = 14'h000C;
    localparam logic [13:0] DSD_M_BIN16_CMP = 14'h000D;
    localparam logic [13:0] DSD_M_TQ16      = 14'h000E;

    // Torque source selector codes
    localparam logic [2:0] DSD_TS_ANALOG  = 3'h0;
    localparam logic [2:0] DSD_TS_PARAM   = 3'h1;
    localparam logic [2:0] DSD_TS_BUS_A   = 3'h3;
    localparam logic [2:0] DSD_TS_DIGITAL = 3'h4;
    localparam logic [2:0] DSD_TS_BUS_B   = 3'h6;

    // Decoded torque source kinds
    localparam logic [2:0] DSD_TK_ANALOG  = 3'h0;
    localparam logic [2:0] DSD_TK_PARAM   = 3'h1;
    localparam logic [2:0] DSD_TK_BUS     = 3'h2;
    localparam logic [2:0] DSD_TK_DIGITAL = 3'h3;
    localparam logic [2:0] DSD_TK_OTHER   = 3'h4;

    // Frequency source codes; 0..5 are the higher-priority inputs
    localparam int          DSD_N_HI       = 6;
    localparam logic [2:0]  DSD_FS_DIGITAL = 3'h6;
    localparam logic [2:0]  DSD_FS_VOLT    = 3'h7;

    // Full-scale torque magnitudes, direct input limit (% units) and direct clamp (0.1 % units)
    localparam logic [15:0] DSD_TQ_FS16    = 16'h7FFF;
    localparam logic [15:0] DSD_TQ_FS12    = 16'h07FF;
    localparam logic [15:0] DSD_TQ_DIR_MAX = 16'h0190;
    localparam logic [15:0] DSD_TQ_LIMIT   = 16'h0FA0;

    // Full-scale frequency inputs
    localparam logic [15:0] DSD_FS_BCD3 = 16'h03E7;
    localparam logic [15:0] DSD_FS_BCD4 = 16'h270F;
    localparam logic [15:0] DSD_FS_BIN12 = 16'h0FFF;
    localparam logic [15:0] DSD_FS_BIN16 = 16'hFFFF;

    // Whole block state
    typedef struct packed {
        logic [13:0]        method;
        logic [1:0]         unit;
        logic [15:0]        bcd_bias;
        logic [15:0]        bcd_gain;
        logic [15:0]        bin_bias;
        logic [15:0]        bin_gain;
        logic [15:0]        tq_bias;
        logic [15:0]        tq_gain;
        logic [2:0]         tq_src;
        logic [31:0]        acc_ref;
        logic [15:0]        held;
        logic               was_bin;
        logic               bcd_err;
        logic [31:0]        freq;
        logic [15:0]        torque;
        logic               tq_valid;
        logic [2:0]         freq_src;
        logic               volt_en;
        logic [2:0]         tq_kind;
        logic               ack;
        logic [31:0]        dat;
    } dsd_state_t;

endpackage : dsd_pkg

// ---- rtl/dsd_word_decode.sv ----
module dsd_word_decode
    import dsd_pkg::*;
(
    input  wire logic [15:0] bits_i,
    input  wire logic        bcd_i,
    input  wire logic        wide_i,
    output logic      [15:0] value_o,
    output logic             invalid_o
);

    // Decimal weight of each nibble
    localparam logic [15:0] WEIGHT [4] = '{16'h0001, 16'h000A, 16'h0064,
                                           16'h03E8};

    logic [3:0]  used;      // Nibble takes part in the word
    logic [3:0]  bad;       // Nibble holds 0AH..0FH
    logic [15:0] part [4];  // Weighted digit value

    // Per-nibble digit check and weighting
    for (genvar g = 0; g < 4; g++) begin : g_nib
        assign used[g] = (g < 3) || wide_i;
        assign bad[g]  = used[g] && (bits_i[4*g+3 -: 4] > 4'h9);
        assign part[g] = used[g] ? 16'(bits_i[4*g+3 -: 4] * WEIGHT[g])
                                 : 16'h0000;
    end

    // Sum digits in BCD, or mask bits in binary
    always_comb begin
        if (bcd_i) begin
            value_o   = 16'(part[0] + part[1] + part[2] + part[3]);
            invalid_o = |bad;
        end else begin
            value_o   = wide_i ? bits_i : {4'h0, bits_i[11:0]};
            invalid_o = 1'b0;
        end
    end

endmodule : dsd_word_decode

// ---- rtl/dsd_setpoint.sv ----
// Contract
// - direct frequency is value times selected increment
// - increment ignored unless gain holds direct code
// - torque taken only in torque-digital configuration
// - top bit sign, lower 15/11 bits magnitude
// - torque word always decoded as binary
// - torque bias at zero, gain at full scale
// - torque bias/gain 0..400%, gain default 150%; register writes are not range-checked
// - sign bit negates the mapped torque
// - direct torque gain uses magnitude as percent
// - direct torque clamps at 400% above 190H
// - invalid BCD digit keeps last valid input
// - binary-to-BCD switch with bad digit gives 0Hz
// - analog compensation added only for 2,3,12,13
// - fixed priority among frequency sources
// - digital source disables analog voltage input
// - accel reference frequency exported with setpoint
// - torque source selector decoding
// - direct gain uses decoded value as frequency
module dsd_setpoint
    import dsd_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Wishbone classic slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // Terminals and drive state
    input  wire logic [15:0]         parallel_input_bits_i,
    input  wire logic                torque_control_i,
    input  wire logic signed [31:0]  analog_comp_i,
    input  wire logic [DSD_N_HI-1:0] hi_valid_i,
    input  wire logic [31:0]         hi_freq_i [DSD_N_HI],
    input  wire logic [31:0]         analog_volt_freq_i,
    // Commands toward speed and torque control
    output logic      [31:0]         freq_setpoint_o,
    output logic      [2:0]          freq_source_o,
    output logic                     analog_volt_enable_o,
    output logic      [31:0]         accel_reference_frequency_o,
    output logic signed [15:0]       torque_command_o,
    output logic                     torque_valid_o,
    output logic      [2:0]          torque_source_kind_o
);

    dsd_state_t s_q;               // Registered state
    dsd_state_t s_d;               // Next state

    logic        bcd_mode;         // BCD frequency method
    logic        bin_mode;         // Binary frequency method
    logic        tq_mode;          // Torque-digital method
    logic        wide;             // 16-bit / 4-digit method
    logic        comp_mode;        // Compensation methods
    logic [15:0] dec_val;          // Decoded input word
    logic        dec_bad;          // Decoded word has bad digit

    // Method classification
    always_comb begin
        bcd_mode  = (s_q.method == DSD_M_BCD3) ||
                    (s_q.method == DSD_M_BCD3_CMP) ||
                    (s_q.method == DSD_M_BCD4) ||
                    (s_q.method == DSD_M_BCD4_CMP);
        bin_mode  = (s_q.method == DSD_M_BIN12) ||
                    (s_q.method == DSD_M_BIN12_CMP) ||
                    (s_q.method == DSD_M_BIN16) ||
                    (s_q.method == DSD_M_BIN16_CMP);
        tq_mode   = (s_q.method == DSD_M_TQ12) ||
                    (s_q.method == DSD_M_TQ16);
        wide      = (s_q.method >= DSD_M_BCD4) &&
                    (s_q.method <= DSD_M_TQ16);
        comp_mode = (s_q.method == DSD_M_BCD3_CMP) ||
                    (s_q.method == DSD_M_BIN12_CMP) ||
                    (s_q.method == DSD_M_BCD4_CMP) ||
                    (s_q.method == DSD_M_BIN16_CMP);
    end

    // Word decoder; torque methods are never BCD
    dsd_word_decode u_dec (
        .bits_i    (parallel_input_bits_i),
        .bcd_i     (bcd_mode),
        .wide_i    (wide),
        .value_o   (dec_val),
        .invalid_o (dec_bad)
    );

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    logic [15:0]        in_val;    // Input value used this cycle
    logic [15:0]        f_bias;    // Active frequency bias
    logic [15:0]        f_gain;    // Active frequency gain
    logic [15:0]        f_fs;      // Active frequency full scale
    logic signed [47:0] f_calc;    // Frequency in 0.01 Hz
    logic [31:0]        f_dig;     // Clamped digital frequency
    logic               dig_valid; // Digital source is valid
    logic [14:0]        t_mag;     // Torque magnitude
    logic               t_sign;    // Torque sign
    logic [15:0]        t_fs;      // Torque full scale
    logic signed [31:0] t_calc;    // Torque in 0.1 %
    logic [31:0]        wr;        // Merged write word
    logic [31:0]        rd;        // Read mux

    // Next-state logic
    always_comb begin
        s_d     = s_q;
        s_d.ack = 1'b0;
        wr      = 32'h0000_0000;
        rd      = 32'h0000_0000;

        // Hold last valid input; bad BCD digits are dropped
        in_val = dec_val;
        if (bcd_mode && dec_bad) begin
            in_val = s_q.was_bin ? 16'h0000 : s_q.held;
        end
        s_d.held    = in_val;
        s_d.was_bin = bin_mode;
        s_d.bcd_err = bcd_mode && dec_bad;

        // Frequency: direct value or bias/gain line
        f_bias = bcd_mode ? s_q.bcd_bias : s_q.bin_bias;
        f_gain = bcd_mode ? s_q.bcd_gain : s_q.bin_gain;
        if (bcd_mode) begin
            f_fs = wide ? DSD_FS_BCD4 : DSD_FS_BCD3;
        end else begin
            f_fs = wide ? DSD_FS_BIN16 : DSD_FS_BIN12;
        end
        if (f_gain == DSD_GAIN_DIRECT) begin
            case (s_q.unit)
                2'h0:    f_calc = 48'(in_val) * 48'sd1000;
                2'h1:    f_calc = 48'(in_val) * 48'sd100;
                2'h2:    f_calc = 48'(in_val) * 48'sd10;
                default: f_calc = 48'(in_val);
            endcase
        end else begin
            // Signed so a gain below the bias gives a falling line
            f_calc = $signed(48'(f_bias)) * 48'sd10 +
                     (($signed(48'(f_gain)) - $signed(48'(f_bias))) *
                      48'sd10 * $signed(48'(in_val))) /
                     $signed(48'(f_fs));
        end
        if (comp_mode) begin
            f_calc = f_calc + 48'(analog_comp_i);
        end
        if (f_calc < 0) begin
            f_dig = 32'h0000_0000;
        end else begin
            f_dig = f_calc[31:0];
        end

        // Source priority, highest index 0
        dig_valid      = bcd_mode || bin_mode;
        s_d.freq       = analog_volt_freq_i;
        s_d.freq_src   = DSD_FS_VOLT;
        s_d.volt_en    = !dig_valid;
        if (dig_valid) begin
            s_d.freq     = f_dig;
            s_d.freq_src = DSD_FS_DIGITAL;
        end
        for (int i = DSD_N_HI - 1; i >= 0; i--) begin
            if (hi_valid_i[i]) begin
                s_d.freq     = hi_freq_i[i];
                s_d.freq_src = 3'(i);
            end
        end

        // Torque word: sign and magnitude
        t_sign = wide ? parallel_input_bits_i[15]
                      : parallel_input_bits_i[11];
        t_mag  = wide ? parallel_input_bits_i[14:0]
                      : {4'h0, parallel_input_bits_i[10:0]};
        t_fs   = wide ? DSD_TQ_FS16 : DSD_TQ_FS12;
        if (s_q.tq_gain == DSD_GAIN_DIRECT) begin
            if (16'(t_mag) > DSD_TQ_DIR_MAX) begin
                t_calc = 32'(DSD_TQ_LIMIT);
            end else begin
                t_calc = 32'(t_mag) * 32'sd10;
            end
        end else begin
            // Signed so a gain below the bias gives a falling line
            t_calc = $signed(32'(s_q.tq_bias)) +
                     (($signed(32'(s_q.tq_gain)) -
                       $signed(32'(s_q.tq_bias))) *
                      $signed(32'(t_mag))) /
                     $signed(32'(t_fs));
        end
        if (t_sign) begin
            t_calc = -t_calc;
        end

        // Torque source decode
        case (s_q.tq_src)
            DSD_TS_ANALOG:  s_d.tq_kind = DSD_TK_ANALOG;
            DSD_TS_PARAM:   s_d.tq_kind = DSD_TK_PARAM;
            DSD_TS_BUS_A,
            DSD_TS_BUS_B:   s_d.tq_kind = DSD_TK_BUS;
            DSD_TS_DIGITAL: s_d.tq_kind = DSD_TK_DIGITAL;
            default:        s_d.tq_kind = DSD_TK_OTHER;
        endcase
        s_d.tq_valid = torque_control_i && tq_mode &&
                       (s_q.tq_src == DSD_TS_DIGITAL);
        s_d.torque   = s_d.tq_valid ? t_calc[15:0] : 16'h0000;

        // Wishbone access, one ack per request
        if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
            s_d.ack = 1'b1;
            case (wb_adr_i)
                DSD_OFF_METHOD:   rd = 32'(s_q.method);
                DSD_OFF_UNIT:     rd = 32'(s_q.unit);
                DSD_OFF_BCD_BIAS: rd = 32'(s_q.bcd_bias);
                DSD_OFF_BCD_GAIN: rd = 32'(s_q.bcd_gain);
                DSD_OFF_BIN_BIAS: rd = 32'(s_q.bin_bias);
                DSD_OFF_BIN_GAIN: rd = 32'(s_q.bin_gain);
                DSD_OFF_TQ_BIAS:  rd = 32'(s_q.tq_bias);
                DSD_OFF_TQ_GAIN:  rd = 32'(s_q.tq_gain);
                DSD_OFF_TQ_SRC:   rd = 32'(s_q.tq_src);
                DSD_OFF_ACC_REF:  rd = s_q.acc_ref;
                DSD_OFF_STATUS:   rd = {24'h000000, s_q.bcd_err,
                                        s_q.tq_valid, s_q.volt_en,
                                        s_q.freq_src, 2'h0};
                DSD_OFF_FREQ:     rd = s_q.freq;
                DSD_OFF_TORQUE:   rd = {{16{s_q.torque[15]}}, s_q.torque};
                default:          rd = 32'h0000_0000;
            endcase
            s_d.dat = rd;
            wr      = merge(rd, wb_dat_i, wb_sel_i);
            if (wb_we_i) begin
                case (wb_adr_i)
                    DSD_OFF_METHOD:   s_d.method   = wr[13:0];
                    DSD_OFF_UNIT:     s_d.unit     = wr[1:0];
                    DSD_OFF_BCD_BIAS: s_d.bcd_bias = wr[15:0];
                    DSD_OFF_BCD_GAIN: s_d.bcd_gain = wr[15:0];
                    DSD_OFF_BIN_BIAS: s_d.bin_bias = wr[15:0];
                    DSD_OFF_BIN_GAIN: s_d.bin_gain = wr[15:0];
                    DSD_OFF_TQ_BIAS:  s_d.tq_bias  = wr[15:0];
                    DSD_OFF_TQ_GAIN:  s_d.tq_gain  = wr[15:0];
                    DSD_OFF_TQ_SRC:   s_d.tq_src   = wr[2:0];
                    DSD_OFF_ACC_REF:  s_d.acc_ref  = wr;
                    default:          ;
                endcase
            end
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q          <= '0;
            s_q.method   <= DSD_RST_METHOD;
            s_q.unit     <= DSD_RST_UNIT;
            s_q.bcd_bias <= DSD_RST_F_BIAS;
            s_q.bcd_gain <= DSD_RST_F_GAIN;
            s_q.bin_bias <= DSD_RST_F_BIAS;
            s_q.bin_gain <= DSD_RST_F_GAIN;
            s_q.tq_bias  <= DSD_RST_TQ_BIAS;
            s_q.tq_gain  <= DSD_RST_TQ_GAIN;
            s_q.tq_src   <= DSD_RST_TQ_SRC;
            s_q.acc_ref  <= DSD_RST_ACC_REF;
            s_q.freq_src <= DSD_FS_VOLT;
            s_q.volt_en  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state
    assign wb_dat_o                    = s_q.dat;
    assign wb_ack_o                    = s_q.ack;
    assign freq_setpoint_o             = s_q.freq;
    assign freq_source_o               = s_q.freq_src;
    assign analog_volt_enable_o        = s_q.volt_en;
    assign accel_reference_frequency_o = s_q.acc_ref;
    assign torque_command_o            = s_q.torque;
    assign torque_valid_o              = s_q.tq_valid;
    assign torque_source_kind_o        = s_q.tq_kind;

endmodule : dsd_setpoint

// ---- tb/dsd_terminal_model.sv ----
module dsd_terminal_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] word_i,   // Word the controller wants to present
    output logic      [15:0] bits_o    // Levels on the input terminals
);
    timeunit 1ns;
    timeprecision 1ns;
    // Outputs change just after a clock edge, like a synchronous controller
    always_ff @(posedge clk_i) begin
        bits_o <= word_i;
    end
endmodule : dsd_terminal_model

// ---- tb/dsd_setpoint_asserts.sv ----
module dsd_setpoint_asserts
    import dsd_pkg::*;
(
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_ack_o,
    input wire logic [DSD_N_HI-1:0] hi_valid_i,
    input wire logic [31:0]        freq_setpoint_o,
    input wire logic [2:0]         freq_source_o,
    input wire logic               analog_volt_enable_o,
    input wire logic signed [15:0] torque_command_o,
    input wire logic               torque_valid_o,
    input wire logic [2:0]         torque_source_kind_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Request seen while no answer is pending
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // Answer is a single-cycle pulse
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_after_req: assert property (s_req |=> s_ack_pulse)
        else $error("bus answer missing or too long");
    a_reset_clears: assert property (disable iff (1'b0) rst_i |=> freq_setpoint_o == 32'h0 && torque_command_o == 16'sh0 && !torque_valid_o && freq_source_o == DSD_FS_VOLT)
        else $error("commands not cleared by reset");
    a_volt_blocked: assert property (freq_source_o == DSD_FS_DIGITAL |-> !analog_volt_enable_o)
        else $error("voltage input enabled with digital source");
    a_jog_first: assert property (hi_valid_i[0] |=> freq_source_o == 3'h0)
        else $error("top priority source not chosen");
    a_stop_second: assert property (hi_valid_i[1:0] == 2'h2 |=> freq_source_o == 3'h1)
        else $error("second priority source not chosen");
    a_tq_idle_zero: assert property (!torque_valid_o |-> torque_command_o == 16'sh0)
        else $error("torque nonzero while not accepted");
    a_tq_digital: assert property (torque_valid_o |-> torque_source_kind_o == DSD_TK_DIGITAL)
        else $error("torque accepted from non-digital source");
    a_tq_limit: assert property (torque_command_o <= 16'sd4000 && torque_command_o >= -16'sd4000)
        else $error("torque command outside limit");
endmodule : dsd_setpoint_asserts

bind dsd_setpoint dsd_setpoint_asserts i_dsd_setpoint_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .hi_valid_i(hi_valid_i),
    .freq_setpoint_o(freq_setpoint_o), .freq_source_o(freq_source_o),
    .analog_volt_enable_o(analog_volt_enable_o),
    .torque_command_o(torque_command_o), .torque_valid_o(torque_valid_o),
    .torque_source_kind_o(torque_source_kind_o));

// ---- tb/tb_top.sv ----
module tb_top
    import dsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic               clk, rst, cyc, stb, we, ack, tq_ctl, volt_en, tq_ok;
    logic [7:0]         adr;          // Bus address
    logic [31:0]        wdat, rdat;   // Bus data
    logic [15:0]        word, bits;   // Controller word and terminal levels
    logic signed [31:0] comp;         // Analog compensation
    logic [DSD_N_HI-1:0] hi_valid;    // Higher-priority sources
    logic [31:0]        hi_freq [DSD_N_HI];
    logic [31:0]        freq, acc;
    logic [2:0]         src, kind;
    logic signed [15:0] tq;
    int                 miscompares = 0;
    int                 checks = 0;
    int                 cycles = 0;
    dsd_terminal_model i_dsd_terminal_model (.clk_i(clk), .word_i(word),
        .bits_o(bits));
    dsd_setpoint i_dsd_setpoint (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .parallel_input_bits_i(bits), .torque_control_i(tq_ctl),
        .analog_comp_i(comp), .hi_valid_i(hi_valid), .hi_freq_i(hi_freq),
        .analog_volt_freq_i(32'h0000_0777), .freq_setpoint_o(freq),
        .freq_source_o(src), .analog_volt_enable_o(volt_en),
        .accel_reference_frequency_o(acc), .torque_command_o(tq),
        .torque_valid_o(tq_ok), .torque_source_kind_o(kind));
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (miscompares == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    task automatic check(input string name, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One classic cycle; ack and read data taken at the same edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) miscompares++;
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input string name, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(name, r, e);
    endtask : rd
    // Terminal word, register writes and outputs all settle within this
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask : settle
    task automatic t_reset_values();
        rd("unit", DSD_OFF_UNIT, 32'h1);
        rd("tq_gain", DSD_OFF_TQ_GAIN, 32'h5DC);
        rd("tq_bias", DSD_OFF_TQ_BIAS, 32'h0);
        rd("unmapped", 8'hFC, 32'h0);
        check("accel_ref", acc, 32'h1770);
        check("volt_freq", freq, 32'h777);
        check("volt_src", {29'h0, src}, 32'h7);
    endtask : t_reset_values
    task automatic t_direct_units();
        wr(DSD_OFF_METHOD, {18'h0, DSD_M_BIN16});
        wr(DSD_OFF_BIN_GAIN, 32'h270F);
        word <= 16'h0100;
        for (int u = 0; u < 4; u++) begin
            wr(DSD_OFF_UNIT, 32'(u));
            settle();
            check("direct_freq", freq, 32'(256000 / (10 ** u)));
            check("digital_src", {29'h0, src}, 32'h6);
            check("volt_off", {31'h0, volt_en}, 32'h0);
        end
        wr(DSD_OFF_BIN_GAIN, 32'h258);
        settle();
        check("scaled_freq", freq, 32'd23);
        wr(DSD_OFF_BIN_GAIN, 32'h270F);
        wr(DSD_OFF_UNIT, 32'h1);
    endtask : t_direct_units
    task automatic t_bcd_faults();
        word <= 16'h00FA;
        wr(DSD_OFF_BCD_GAIN, 32'h270F);
        settle();
        check("bin_before", freq, 32'd25000);
        wr(DSD_OFF_METHOD, {18'h0, DSD_M_BCD4});
        settle();
        check("bin_to_bcd", freq, 32'h0);
        word <= 16'h0111;
        settle();
        check("bcd_freq", freq, 32'd11100);
        word <= 16'h011A;
        settle();
        check("bcd_hold", freq, 32'd11100);
    endtask : t_bcd_faults
    task automatic t_compensation();
        word <= 16'h0100;
        comp <= 32'sd500;
        wr(DSD_OFF_METHOD, {18'h0, DSD_M_BIN16_CMP});
        settle();
        check("comp_on", freq, 32'd26100);
        wr(DSD_OFF_METHOD, {18'h0, DSD_M_BIN16});
        settle();
        check("comp_off", freq, 32'd25600);
        comp <= 32'sd0;
    endtask : t_compensation
    task automatic t_priority();
        for (int i = 0; i < DSD_N_HI; i++) begin
            hi_valid <= 6'h3F << i;
            settle();
            check("hi_src", {29'h0, src}, 32'(i));
            check("hi_freq", freq, 32'(1000 * (i + 1)));
        end
        hi_valid <= 6'h0;
    endtask : t_priority
    task automatic t_torque();
        tq_ctl <= 1'b1;
        wr(DSD_OFF_METHOD, {18'h0, DSD_M_TQ16});
        wr(DSD_OFF_TQ_SRC, 32'h4);
        word <= 16'h7FFF;
        settle();
        check("tq_kind", {29'h0, kind}, 32'h3);
        check("tq_full", 32'(tq), 32'd1500);
        word <= 16'hFFFF;
        settle();
        check("tq_neg", 32'(tq), -32'sd1500);
        wr(DSD_OFF_TQ_GAIN, 32'h270F);
        word <= 16'h8064;
        settle();
        check("tq_direct", 32'(tq), -32'sd1000);
        word <= 16'h0200;
        settle();
        check("tq_clamp", 32'(tq), 32'd4000);
        word <= 16'h0099;
        settle();
        check("tq_no_bcd", 32'(tq), 32'd1530);
        wr(DSD_OFF_TQ_GAIN, 32'h5DC);
        wr(DSD_OFF_METHOD, {18'h0, DSD_M_TQ12});
        word <= 16'hFFFF;
        settle();
        check("tq12_neg", 32'(tq), -32'sd1500);
        tq_ctl <= 1'b0;
        settle();
        check("tq_no_ctl", {31'h0, tq_ok}, 32'h0);
        wr(DSD_OFF_TQ_SRC, 32'h0);
        settle();
        check("tq_analog", {31'h0, tq_ok}, 32'h0);
        check("kind_analog", {29'h0, kind}, 32'h0);
    endtask : t_torque
    // Main sequence
    initial begin
        rst = 1'b1;
        {cyc, stb, we, tq_ctl} = 4'h0;
        adr = 8'h00;
        wdat = 32'h0;
        word = 16'h0;
        comp = 32'sd0;
        hi_valid = 6'h0;
        for (int i = 0; i < DSD_N_HI; i++) hi_freq[i] = 32'(1000 * (i + 1));
        repeat (10) @(posedge clk);
        check("freq_reset", freq, 32'h0);
        rst <= 1'b0;
        @(posedge clk);
        t_reset_values();
        t_direct_units();
        t_bcd_faults();
        t_compensation();
        t_priority();
        t_torque();
        complete_run();
    end
endmodule : tb_top
